// ### bsc_pkg.sv
// ============================================================================
// Shared constants and types for the boundary-scan chain.
// ============================================================================
package bsc_pkg;

  // ==========================================================================
  // Pad and output-enable group sizes
  // ==========================================================================
  localparam int PAD_N = 84;
  localparam int OE_N = 25;
  localparam int PCI_LO = 0;
  localparam int PCI_HI = 49;
  localparam int SROM_LO = 64;
  localparam int SROM_HI = 66;
  localparam int PAD_AD_LO = 5;
  localparam int OE_AD = 7;
  localparam int RING_EARLY = 109;
  localparam int RING_LATER = 112;

  // ==========================================================================
  // Instruction codes
  // ==========================================================================
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_SAMPLE = 3'h1;
  localparam logic [2:0] IR_TRISTATE = 3'h5;
  localparam logic [2:0] IR_CONTINUITY = 3'h6;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [2:0] IR_CAPTURE = 3'h1;

  localparam logic [4:0] OE_ALWAYS = 5'h1E;
  localparam logic [4:0] OE_NEVER = 5'h1F;

  typedef enum logic [3:0] {
    S_TLR, S_RTI, S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PAU_DR, S_EX2_DR,
    S_UPD_DR, S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PAU_IR, S_EX2_IR, S_UPD_IR
  } bsc_tap_t;

  // Word handed from the test clock side to the system clock side.
  typedef struct packed {
    logic extest;
    logic tristate;
    logic [OE_N-1:0] oe;
    logic [PAD_N-1:0] data;
  } bsc_drive_t;

  // Output-enable cell that governs each pad, or always / never driven.
  function automatic logic [4:0] bsc_oe_of(input int p, input bit later);
    logic [4:0] r;
    r = OE_ALWAYS;
    if (p >= 5 && p <= 36) r = 5'h07;
    else if (p >= 37 && p <= 40) r = 5'h00;
    else if (p >= 42 && p <= 47) r = 5'(p - 41);
    else if (p == 49) r = 5'h08;
    else if (p == 1 || p == 2 || p == 3 || p == 41 || p == 65 || p == 67 || p == 75) r = OE_NEVER;
    else if (p == 50) r = later ? 5'h18 : OE_ALWAYS;
    else if (p >= 52 && p <= 59) r = 5'h16;
    else if (p >= 60 && p <= 63) r = 5'(p - 51);
    else if (p == 68) r = 5'h0D;
    else if (p >= 69 && p <= 72) r = 5'h0E;
    else if (p == 73) r = 5'h0F;
    else if (p == 74) r = 5'h10;
    else if (p == 76) r = 5'h12;
    else if (p == 77) r = 5'h13;
    else if (p >= 78 && p <= 81) r = 5'h14;
    else if (p == 82) r = later ? 5'h17 : OE_ALWAYS;
    else if (p == 83) r = 5'h15;
    return r;
  endfunction : bsc_oe_of

endpackage : bsc_pkg

// ### bsc_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Two-stage synchroniser.
// ============================================================================
module bsc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // Destination clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic [WIDTH-1:0] d_i, // Asynchronous input.
  output logic [WIDTH-1:0] q_o // Synchronised output.
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= '0;
      q_o <= '0;
    end
    else
    begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule : bsc_sync
`default_nettype wire

// ### bsc_chain.sv
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - Scan cells at PCI, ROM, GEP, MII pads.
// - Ring also observes pad output-enable controls.
// - EXTEST with enable cell set drives pins.
// - Earlier ring order from tdi to tdo.
// - Later ring adds three extra cells.
// - Two internal cells, no pad, earlier ring.
// - Later ring holds a third internal cell.
// - TAP interprets tms, dispatches test controls.
// - Full sixteen-state TAP state machine.
// - Three-bit instruction decode, reserved codes bypass.
// - Reset selects bypass instruction automatically.
// - One-bit bypass register between tdi, tdo.
module bsc_chain import bsc_pkg::*; #(
  parameter bit LATER = 1'b1
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire logic tck_i, // Test clock from the tester.
  input wire logic tms_i, // Test mode select.
  input wire logic tdi_i, // Test data in.
  output logic tdo_o, // Test data out.
  output logic tdo_oe_o, // Test data out enable.
  input wire logic [PAD_N-1:0] pad_in_i, // Pin levels.
  input wire logic [PAD_N-1:0] core_out_i, // Functional pad data.
  input wire logic [OE_N-1:0] core_oe_grp_i, // Functional enable groups.
  output logic [PAD_N-1:0] pad_out_o, // Pad data to pins.
  output logic [PAD_N-1:0] pad_oe_o // Pad enables to pins.
);

  localparam int RING_N = LATER ? RING_LATER : RING_EARLY;

  // ==========================================================================
  // Test clock domain: reset, observation and acknowledge synchronisers
  // ==========================================================================
  wire logic rst_t;
  wire logic [PAD_N-1:0] pin_s;
  wire logic [OE_N-1:0] oe_s;
  wire logic ack_t;
  logic ack;

  bsc_sync #(.WIDTH(1)) u_rst_sync (
    .clk_i(tck_i),
    .rst_i(1'b0),
    .d_i(rst_i),
    .q_o(rst_t)
  );

  bsc_sync #(.WIDTH(PAD_N + OE_N)) u_obs_sync (
    .clk_i(tck_i),
    .rst_i(rst_t),
    .d_i({core_oe_grp_i, pad_in_i}),
    .q_o({oe_s, pin_s})
  );

  bsc_sync #(.WIDTH(1)) u_ack_sync (
    .clk_i(tck_i),
    .rst_i(rst_t),
    .d_i(ack),
    .q_o(ack_t)
  );

  // ==========================================================================
  // TAP state machine
  // ==========================================================================
  bsc_tap_t state;
  bsc_tap_t next_state;

  always_comb
  begin
    next_state = state;
    case (state)
      S_TLR: next_state = tms_i ? S_TLR : S_RTI;
      S_RTI: next_state = tms_i ? S_SEL_DR : S_RTI;
      S_SEL_DR: next_state = tms_i ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: next_state = tms_i ? S_EX1_DR : S_SH_DR;
      S_SH_DR: next_state = tms_i ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: next_state = tms_i ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: next_state = tms_i ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: next_state = tms_i ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: next_state = tms_i ? S_SEL_DR : S_RTI;
      S_SEL_IR: next_state = tms_i ? S_TLR : S_CAP_IR;
      S_CAP_IR: next_state = tms_i ? S_EX1_IR : S_SH_IR;
      S_SH_IR: next_state = tms_i ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: next_state = tms_i ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: next_state = tms_i ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: next_state = tms_i ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: next_state = tms_i ? S_SEL_DR : S_RTI;
      default: next_state = S_TLR;
    endcase
  end

  // The tester presents tms and tdi settled before each rising edge, so they
  // are used here without a synchroniser.
  always_ff @(posedge tck_i)
  begin
    if (rst_t)
      state <= S_TLR;
    else
      state <= next_state;
  end

  // ==========================================================================
  // Instruction register
  // ==========================================================================
  logic [2:0] ir_sr;
  logic [2:0] ir;
  wire logic sel_bsr = (ir == IR_EXTEST) || (ir == IR_SAMPLE);

  always_ff @(posedge tck_i)
  begin
    if (rst_t)
      ir_sr <= IR_CAPTURE;
    else if (state == S_CAP_IR)
      ir_sr <= IR_CAPTURE;
    else if (state == S_SH_IR)
      ir_sr <= {tdi_i, ir_sr[2:1]};
  end

  // Reserved codes and continuity leave the bypass register selected.
  always_ff @(posedge tck_i)
  begin
    if (rst_t || state == S_TLR)
      ir <= IR_BYPASS;
    else if (state == S_UPD_IR)
      ir <= ir_sr;
  end

  // ==========================================================================
  // Data registers: bypass bit and boundary ring
  // ==========================================================================
  logic byp;
  logic [RING_N-1:0] bsr;
  logic [RING_N-1:0] upd;
  wire logic [RING_N-1:0] cap;
  wire logic [PAD_N-1:0] upd_pad;
  wire logic [OE_N-1:0] upd_oe;
  wire logic [2:0] int_q;

  // Bit 0 sits next to tdi; tdo reads the top bit.
  generate
    if (LATER)
    begin : g_later
      assign cap = {oe_s[21:13], oe_s[23], pin_s[83:67], int_q[1], pin_s[66:64],
                    oe_s[12:9], pin_s[63:60], oe_s[24], oe_s[22], pin_s[59:50],
                    int_q[0], int_q[2], oe_s[8:0], pin_s[49:0]};
      assign {upd_oe[21:13], upd_oe[23], upd_pad[83:67], int_q[1], upd_pad[66:64],
              upd_oe[12:9], upd_pad[63:60], upd_oe[24], upd_oe[22], upd_pad[59:50],
              int_q[0], int_q[2], upd_oe[8:0], upd_pad[49:0]} = upd;
    end
    else
    begin : g_early
      assign cap = {oe_s[21:13], pin_s[83:67], int_q[1], pin_s[66:64], oe_s[12:9],
                    pin_s[63:60], oe_s[22], pin_s[59:50], int_q[0], oe_s[8:0],
                    pin_s[49:0]};
      assign {upd_oe[21:13], upd_pad[83:67], int_q[1], upd_pad[66:64], upd_oe[12:9],
              upd_pad[63:60], upd_oe[22], upd_pad[59:50], int_q[0], upd_oe[8:0],
              upd_pad[49:0]} = upd;
      assign upd_oe[24:23] = 2'h0;
      assign int_q[2] = 1'b0;
    end
  endgenerate

  always_ff @(posedge tck_i)
  begin
    if (rst_t)
      byp <= 1'b0;
    else if (state == S_CAP_DR && !sel_bsr)
      byp <= 1'b0;
    else if (state == S_SH_DR && !sel_bsr)
      byp <= tdi_i;
  end

  always_ff @(posedge tck_i)
  begin
    if (rst_t)
      bsr <= '0;
    else if (state == S_CAP_DR && sel_bsr)
      bsr <= cap;
    else if (state == S_SH_DR && sel_bsr)
      bsr <= {bsr[RING_N-2:0], tdi_i};
  end

  always_ff @(posedge tck_i)
  begin
    if (rst_t)
      upd <= '0;
    else if (state == S_UPD_DR && sel_bsr)
      upd <= bsr;
  end

  // ==========================================================================
  // Test data out, changed on the falling edge
  // ==========================================================================
  wire logic shift_bit = (state == S_SH_IR) ? ir_sr[0] : (sel_bsr ? bsr[RING_N-1] : byp);

  always_ff @(negedge tck_i)
  begin
    if (rst_t)
    begin
      tdo_o <= 1'b0;
      tdo_oe_o <= 1'b0;
    end
    else
    begin
      tdo_o <= shift_bit;
      tdo_oe_o <= (state == S_SH_DR) || (state == S_SH_IR);
    end
  end

  // ==========================================================================
  // Handshake of the drive word into the system clock domain
  // ==========================================================================
  // The word is held until acknowledged; updates that come faster than the
  // handshake are merged, so pins always settle on the latest latch contents.
  bsc_drive_t xfer;
  bsc_drive_t live;
  logic req;
  logic dirty;
  wire logic req_c;
  wire logic idle = (req == ack_t);
  wire logic upd_evt = (state == S_UPD_DR) || (state == S_UPD_IR) || (state == S_TLR && ir != IR_BYPASS);
  wire bsc_drive_t cur = {ir == IR_EXTEST, ir == IR_TRISTATE, upd_oe, upd_pad};

  always_ff @(posedge tck_i)
  begin
    if (rst_t)
    begin
      dirty <= 1'b1;
      req <= 1'b0;
      xfer <= '0;
    end
    else
    begin
      dirty <= upd_evt | (dirty & ~idle);
      if (idle && dirty)
      begin
        xfer <= cur;
        req <= ~req;
      end
    end
  end

  bsc_sync #(.WIDTH(1)) u_req_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(req),
    .q_o(req_c)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack <= 1'b0;
      live <= '0;
    end
    else if (req_c != ack)
    begin
      ack <= req_c;
      live <= xfer;
    end
  end

  // ==========================================================================
  // Pad drive selection
  // ==========================================================================
  wire logic [PAD_N-1:0] fn_en;
  wire logic [PAD_N-1:0] ext_en;
  wire logic [PAD_N-1:0] next_out;
  wire logic [PAD_N-1:0] next_oe;

  generate
    for (genvar g = 0; g < PAD_N; g++)
    begin : g_pad
      localparam logic [4:0] C = bsc_oe_of(g, LATER);
      localparam bit FLOATS = (g >= PCI_LO && g <= PCI_HI) || (g >= SROM_LO && g <= SROM_HI);
      if (C == OE_ALWAYS)
      begin : g_alw
        assign fn_en[g] = 1'b1;
        assign ext_en[g] = 1'b1;
      end
      else if (C == OE_NEVER)
      begin : g_nev
        assign fn_en[g] = 1'b0;
        assign ext_en[g] = 1'b0;
      end
      else
      begin : g_cell
        assign fn_en[g] = core_oe_grp_i[C];
        assign ext_en[g] = live.oe[C];
      end
      assign next_oe[g] = live.extest ? ext_en[g] : (fn_en[g] & ~(FLOATS & live.tristate));
      assign next_out[g] = live.extest ? live.data[g] : core_out_i[g];
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pad_out_o <= '0;
      pad_oe_o <= '0;
    end
    else
    begin
      pad_out_o <= next_out;
      pad_oe_o <= next_oe;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  property p_tlr;
    @(posedge tck_i) disable iff (rst_t) tms_i [*5] |=> state == S_TLR;
  endproperty
  a_tlr: assert property (p_tlr) else $error("Five tms highs did not reach reset state.");

  property p_ir_reset;
    @(posedge tck_i) disable iff (rst_t) state == S_TLR |=> ir == IR_BYPASS;
  endproperty
  a_ir_reset: assert property (p_ir_reset) else $error("Reset state did not select bypass.");

  property p_ir_load;
    @(posedge tck_i) disable iff (rst_t) state == S_UPD_IR |=> ir == $past(ir_sr);
  endproperty
  a_ir_load: assert property (p_ir_load) else $error("Instruction not loaded on update.");

  property p_ir_cap;
    @(posedge tck_i) disable iff (rst_t) state == S_SEL_IR && !tms_i ##1 state == S_CAP_IR |=> ir_sr == IR_CAPTURE;
  endproperty
  a_ir_cap: assert property (p_ir_cap) else $error("Instruction capture pattern wrong.");

  property p_byp;
    @(posedge tck_i) disable iff (rst_t) state == S_SH_DR && !sel_bsr |=> byp == $past(tdi_i);
  endproperty
  a_byp: assert property (p_byp) else $error("Bypass bit did not take tdi.");

  property p_shift;
    @(posedge tck_i) disable iff (rst_t)
      state == S_SH_DR && sel_bsr |=> bsr[0] == $past(tdi_i) && bsr[RING_N-1:1] == $past(bsr[RING_N-2:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("Ring did not shift by one cell.");

  property p_cap;
    @(posedge tck_i) disable iff (rst_t) state == S_CAP_DR && sel_bsr |=> bsr == $past(cap);
  endproperty
  a_cap: assert property (p_cap) else $error("Ring did not capture pads and enables.");

  property p_tdo;
    @(negedge tck_i) disable iff (rst_t) state == S_SH_DR && sel_bsr |=> tdo_o == $past(bsr[RING_N-1]);
  endproperty
  a_tdo: assert property (p_tdo) else $error("Test data out not last ring cell.");

  property p_extest;
    @(posedge clk_i) disable iff (rst_i)
      live.extest && live.oe[OE_AD] |=> pad_oe_o[PAD_AD_LO] && pad_out_o[PAD_AD_LO] == $past(live.data[PAD_AD_LO]);
  endproperty
  a_extest: assert property (p_extest) else $error("Enabled pad not driven from scan latch.");

  property p_tristate;
    @(posedge clk_i) disable iff (rst_i) !live.extest && live.tristate |=> pad_oe_o[PCI_HI:PCI_LO] == '0;
  endproperty
  a_tristate: assert property (p_tristate) else $error("Bus pads driven in tristate mode.");

endmodule : bsc_chain
`default_nettype wire

// ### bsc_tester.sv
`timescale 1ns/10ps
`default_nettype none
// ============================================================================
// Board test controller: the test clock runs only inside frames.
// ============================================================================
module bsc_tester (
  output logic tck_o, // Test clock, 30 ns period.
  output logic tms_o, // Test mode select.
  output logic tdi_o, // Test data in.
  input wire logic [1:0] tdo_i // Test data out of both rings.
);
  logic [1:0] last;

  initial
  begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
    last = 2'h0;
  end

  // Inputs change while the clock is low, so they are settled at each rise.
  task automatic step(input logic m, input logic d);
  begin
    tms_o = m;
    tdi_o = d;
    #15 last = tdo_i;
    tck_o = 1'b1;
    #15 tck_o = 1'b0;
  end
  endtask : step

  // A released data line toggles so that a stale bit is never mistaken for data.
  task automatic idle(input int n);
  begin
    repeat (n) step(1'b0, ~tdi_o);
  end
  endtask : idle

  // Five ones reach Test-Logic-Reset from any state, then park in Run-Test/Idle.
  task automatic reset;
  begin
    repeat (5) step(1'b1, ~tdi_o);
    step(1'b0, ~tdi_o);
  end
  endtask : reset

  // Instruction bits go in low bit first; data bits go in top index first.
  task automatic scan(input bit ir, input int n, input logic [111:0] din, output logic [111:0] q0,
                      output logic [111:0] q1);
    int i;
  begin
    q0 = '0;
    q1 = '0;
    step(1'b1, ~tdi_o);
    if (ir)
    begin
      step(1'b1, ~tdi_o);
    end
    step(1'b0, ~tdi_o);
    step(1'b0, ~tdi_o);
    for (i = 0; i < n; i++)
    begin
      step(i == n - 1, ir ? din[i] : din[n - 1 - i]);
      q0 = {q0[110:0], last[0]};
      q1 = {q1[110:0], last[1]};
    end
    step(1'b1, ~tdi_o);
    idle(6);
  end
  endtask : scan

endmodule : bsc_tester
`default_nettype wire

// ### test_boundary_scan_chain.sv
`timescale 1ns/10ps
`default_nettype none
module test_boundary_scan_chain import bsc_pkg::*;;
  logic clk_i, rst_i, tck, tms, tdi;
  wire logic [1:0] tdo, tdo_oe;
  logic [PAD_N-1:0] pad_in_i, core_out_i, pout_u, poe_u, pout_e, poe_e;
  logic [OE_N-1:0] core_oe_grp_i;
  logic [111:0] q0, q1, a, b, e;
  int fails, check_count;

  bsc_tester tst_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  bsc_chain #(.LATER(1'b1)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo[0]), .tdo_oe_o(tdo_oe[0]), .pad_in_i(pad_in_i), .core_out_i(core_out_i),
    .core_oe_grp_i(core_oe_grp_i), .pad_out_o(pout_u), .pad_oe_o(poe_u));
  bsc_chain #(.LATER(1'b0)) dut_early_u (.clk_i(clk_i), .rst_i(rst_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo[1]), .tdo_oe_o(tdo_oe[1]), .pad_in_i(pad_in_i), .core_out_i(core_out_i),
    .core_oe_grp_i(core_oe_grp_i), .pad_out_o(pout_e), .pad_oe_o(poe_e));

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ==========================================================================
  // Checking and reporting
  // ==========================================================================
  task automatic chk(input logic [111:0] got, input logic [111:0] exp);
  begin
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  end
  endtask : chk

  task automatic test_done;
  begin
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  end
  endtask : test_done

  // The enable word crosses into the system clock by handshake, so its arrival is polled.
  task automatic wait_oe(input int p, input logic v);
    int k;
  begin
    k = 0;
    while ((poe_u[p] !== v || poe_e[p] !== v) && k < 40)
    begin
      @(posedge clk_i);
      k++;
    end
    if (k == 40)
    begin
      fails++;
      test_done();
    end
    @(posedge clk_i);
    #1;
  end
  endtask : wait_oe

  // Expected ring image, top index nearest the data output; n holds cells {c, b, a}.
  function automatic logic [111:0] ring(input logic [83:0] p, input logic [24:0] o, input logic [2:0] n,
                                        input bit lat);
  begin
    if (lat)
      return {o[21:13], o[23], p[83:67], n[1], p[66:64], o[12:9], p[63:60], o[24], o[22], p[59:50], n[0], n[2],
              o[8:0], p[49:0]};
    return {3'h0, o[21:13], p[83:67], n[1], p[66:64], o[12:9], p[63:60], o[22], p[59:50], n[0], o[8:0], p[49:0]};
  end
  endfunction : ring

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic sc_bypass;
  begin
    tst_u.scan(1'b0, 8, 112'hB5, q0, q1);
    chk({q1[7:0], q0[7:0]}, 16'h5A5A);
    chk(tdo_oe, 2'h0);
    chk(pout_u, core_out_i);
  end
  endtask : sc_bypass

  task automatic sc_modes;
    logic [2:0] c;
  begin
    for (int j = 0; j < 5; j++)
    begin
      c = (j < 3) ? 3'(j + 2) : 3'(j + 3);
      tst_u.scan(1'b1, 3, 112'(c), q0, q1);
      chk({q1[2:0], q0[2:0]}, 6'h24);
      tst_u.scan(1'b0, 8, 112'h4E, q0, q1);
      chk({q1[7:0], q0[7:0]}, 16'h2727);
      chk(pout_e, core_out_i);
    end
  end
  endtask : sc_modes

  task automatic sc_sample;
  begin
    tst_u.scan(1'b1, 3, 112'(IR_SAMPLE), q0, q1);
    a = 112'h9C3E_51A7_D20B_6F34_81E5_C97A_02DB;
    tst_u.scan(1'b0, 112, a, q0, q1);
    @(posedge clk_i);
    #1 pad_in_i = 84'h3_C5A9_E106_7BD2_48F3_6A1E;
    core_oe_grp_i = 25'h1A5C366;
    tst_u.idle(4);
    b = ~a;
    b[57] = 1'b1;
    b[51] = 1'b0;
    b[72] = 1'b0;
    tst_u.scan(1'b0, 112, b, q0, q1);
    chk(q0, ring(pad_in_i, core_oe_grp_i, {a[59], a[84], a[60]}, 1'b1));
    e = ring(pad_in_i, core_oe_grp_i, {1'b0, a[82], a[59]}, 1'b0);
    chk(q1[111:3], e[108:0]);
  end
  endtask : sc_sample

  task automatic sc_extest;
  begin
    tst_u.scan(1'b1, 3, 112'(IR_EXTEST), q0, q1);
    wait_oe(10, 1'b1);
    chk({poe_u[10], poe_u[42], poe_u[0], poe_u[1], poe_u[50]}, 5'h14);
    chk({poe_e[10], poe_e[42], poe_e[50]}, 3'h5);
    chk({pout_u[10], pout_u[42], pout_e[10]}, {b[10], b[42], b[10]});
  end
  endtask : sc_extest

  task automatic sc_tristate;
  begin
    tst_u.scan(1'b1, 3, 112'(IR_TRISTATE), q0, q1);
    wait_oe(10, 1'b0);
    chk({poe_u[49:0], poe_u[66:64], poe_e[49:0], poe_e[66:64]}, 106'h0);
    chk(pout_u[83:67], core_out_i[83:67]);
  end
  endtask : sc_tristate

  // Test-logic reset by the select line alone must fall back to bypass.
  task automatic sc_tms_reset;
  begin
    tst_u.reset();
    sc_bypass();
    wait_oe(0, 1'b1);
    chk(pout_e, core_out_i);
  end
  endtask : sc_tms_reset

  initial
  begin
    fails = 0;
    check_count = 0;
    rst_i = 1'b1;
    pad_in_i = 84'h0_F0F0_0FF0_A55A_3CC3_9669;
    core_out_i = 84'h5_A3C9_0F17_E2B4_6D81_C3F5;
    core_oe_grp_i = 25'h0;
    // The reset is synchronised into the test clock, so that clock must run meanwhile.
    fork
      tst_u.reset();
      repeat (3) @(posedge clk_i);
    join
    #1 rst_i = 1'b0;
    tst_u.idle(6);
    tst_u.reset();
    sc_bypass();
    sc_modes();
    sc_sample();
    sc_extest();
    sc_tristate();
    sc_tms_reset();
    test_done();
  end
endmodule : test_boundary_scan_chain
`default_nettype wire
